//--- logic/mbic_control.sv
// Behaviour
// - manual forward blocked on first sensor edge or steady active level
// - forward re-enabled by sensor falling edge or auto-and-back mode change
// - second sensor locks and re-enables reverse the same way
// - starter: lock allows only automatic; speed ctrl: opposite manual allowed
// - starter with edge select: lock reacts to edges only
// - indicator steady when selected direction is not locked (starter: neither direction locked)
// - indicator flashes when selected direction is locked out
// - starter actuates brake with start signal in both modes
// - brake sequence select: 0 simple, 1 advanced, default 0
// - open threshold default 1.5, only effective with run enable
// - close threshold default 1
// - torque threshold default 0, skipped when control method is 6
// - release delay 0 to 320 s, default 0
// - simple: release brake once output frequency exceeds open threshold
// - stop: apply brake below close threshold, ramp to zero, disable
// - advanced: ramp to open, wait torque, release, hold delay, setpoint
// - starter releases brake on start after its release delay
// - starter waits apply delay between brake close and output disable
// - each sensor edge polarity is selectable
`timescale 1ns/1ns
`default_nettype none
module mbic_control
    import mbic_pkg::*;
#(
    parameter int TICK_CYC  = mbic_pkg::TICK_CYCLES,
    parameter int FLASH_CYC = mbic_pkg::FLASH_CYCLES
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset,
    // variant and mode
    input  wire logic                        starterVariant,
    input  wire logic                        edgeInterlockSelect,
    input  wire logic                        autoMode,
    // sensors and selector
    input  wire logic                        firstSensorInput,
    input  wire logic                        secondSensorInput,
    input  wire logic                        firstSensorFalling,
    input  wire logic                        secondSensorFalling,
    input  wire logic                        selForward,
    input  wire logic                        selReverse,
    // run commands
    input  wire logic                        autoForward,
    input  wire logic                        autoReverse,
    // brake settings
    input  wire logic                        brakeSequenceSelect,
    input  wire logic [mbic_pkg::FREQ_W-1:0] brakeOpenFrequency,
    input  wire logic [mbic_pkg::FREQ_W-1:0] brakeCloseFrequency,
    input  wire logic [mbic_pkg::TORQ_W-1:0] torqueLevel,
    input  wire logic [mbic_pkg::DLY_W-1:0]  releaseDelay,
    input  wire logic [mbic_pkg::DLY_W-1:0]  applyDelay,
    input  wire logic [2:0]                  motorControlMethod,
    // drive feedback
    input  wire logic [mbic_pkg::FREQ_W-1:0] outputFrequency,
    input  wire logic [mbic_pkg::TORQ_W-1:0] motorTorque,
    // outputs
    output logic                             runForward_r,
    output logic                             runReverse_r,
    output logic                             ledForward_r,
    output logic                             ledReverse_r,
    output logic                             brakeRelease_r,
    output logic                             driveEnable_r,
    output logic                             freqHold_r,
    output logic                             rampDown_r,
    output logic [1:0]                       lockState_r
);
    import mbic_pkg::*;

    // active level of a sensor after polarity selection
    function automatic logic senseLvl(input logic raw, input logic fall);
        senseLvl = raw ^ fall;
    endfunction

    logic [1:0] lockSel, noLockSel;
    wire logic [1:0] sensNow, sensPrev, locked_r;
    logic [1:0] fallPol;
    logic       autoPrev_r;
    logic       backToManual;
    assign fallPol  = {secondSensorFalling, firstSensorFalling};
    assign lockSel  = {selReverse, selForward};
    assign backToManual = autoPrev_r & ~autoMode;

    // per-direction interlock: idx 0 forward, idx 1 reverse
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gLock
            logic raw;
            logic prev_r;
            logic lock_r;
            assign raw = (g == 0) ? firstSensorInput : secondSensorInput;
            assign sensNow[g] = senseLvl(raw, fallPol[g]);
            // each direction owns its flops; the vectors are plain nets so
            // no packed variable ends up with two clocked writers
            assign sensPrev[g] = prev_r;
            assign locked_r[g] = lock_r;
            always_ff @(posedge clk) begin
                if (reset) begin
                    prev_r <= 1'b0;
                    lock_r <= 1'b0;
                end else begin
                    prev_r <= sensNow[g];
                    // auto-and-back clears; edge sets and wins
                    if (sensNow[g] & ~sensPrev[g]) begin
                        lock_r <= 1'b1;
                    end else if (sensNow[g] & ~(starterVariant
                                 & edgeInterlockSelect) & ~backToManual) begin
                        lock_r <= 1'b1;
                    end else if ((~sensNow[g] & sensPrev[g])
                                 | backToManual) begin
                        lock_r <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (reset) begin
            autoPrev_r <= 1'b0;
        end else begin
            autoPrev_r <= autoMode;
        end
    end

    // manual permission: starter blocks all manual travel while any lock
    logic anyLock;
    assign anyLock = |locked_r;
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            noLockSel[i] = lockSel[i] & ~locked_r[i]
                           & ~(starterVariant & anyLock);
        end
    end

    // requested direction
    logic wantFwd, wantRev, wantRun;
    assign wantFwd = autoMode ? autoForward : noLockSel[0];
    assign wantRev = autoMode ? (autoReverse & ~autoForward)
                              : (noLockSel[1] & ~noLockSel[0]);
    assign wantRun = wantFwd | wantRev;

    // flash timebase
    logic [PRE_W-1:0] flashCnt_r;
    logic             flash_r;
    always_ff @(posedge clk) begin
        if (reset) begin
            flashCnt_r <= '0;
            flash_r    <= 1'b0;
        end else if (flashCnt_r == PRE_W'(FLASH_CYC - 1)) begin
            flashCnt_r <= '0;
            flash_r    <= ~flash_r;
        end else begin
            flashCnt_r <= flashCnt_r + PRE_W'(1);
        end
    end

    // indicators in manual mode; steady when free, flashing when locked
    always_ff @(posedge clk) begin
        if (reset) begin
            ledForward_r <= 1'b0;
            ledReverse_r <= 1'b0;
            lockState_r  <= 2'b00;
        end else begin
            ledForward_r <= autoMode ? runForward_r
                          : (noLockSel[0] | (selForward & flash_r));
            ledReverse_r <= autoMode ? runReverse_r
                          : (noLockSel[1] | (selReverse & flash_r));
            lockState_r  <= locked_r;
        end
    end

    // 100 ms tick for delay counting
    logic [PRE_W-1:0] tickCnt_r;
    logic             tick;
    assign tick = (tickCnt_r == PRE_W'(TICK_CYC - 1));
    always_ff @(posedge clk) begin
        if (reset || tick) begin
            tickCnt_r <= '0;
        end else begin
            tickCnt_r <= tickCnt_r + PRE_W'(1);
        end
    end

    // brake sequencer
    mbic_state_t state_r;
    logic [DLY_W-1:0] dly_r;
    logic [DLY_W-1:0] relDly, aplDly;
    logic torqueOk, aboveOpen, belowClose;
    // clamp delays so an out-of-range setting cannot exceed 320 s
    assign relDly = (releaseDelay > DLY_MAX) ? DLY_MAX : releaseDelay;
    assign aplDly = (applyDelay > DLY_MAX) ? DLY_MAX : applyDelay;
    assign torqueOk = (motorControlMethod == METHOD_VF)
                    | (motorTorque >= torqueLevel);
    assign aboveOpen  = wantRun
                      & (outputFrequency > brakeOpenFrequency);
    assign belowClose = outputFrequency < brakeCloseFrequency;

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r        <= MBIC_IDLE;
            brakeRelease_r <= 1'b0;
            driveEnable_r  <= 1'b0;
            freqHold_r     <= 1'b0;
            rampDown_r     <= 1'b0;
            runForward_r   <= 1'b0;
            runReverse_r   <= 1'b0;
            dly_r          <= '0;
        end else begin
            if (tick && dly_r != '0) begin
                dly_r <= dly_r - DLY_W'(1);
            end
            case (state_r)
                MBIC_IDLE: begin
                    brakeRelease_r <= 1'b0;
                    driveEnable_r  <= 1'b0;
                    rampDown_r     <= 1'b0;
                    freqHold_r     <= 1'b0;
                    if (wantRun) begin
                        runForward_r  <= wantFwd;
                        runReverse_r  <= wantRev;
                        driveEnable_r <= 1'b1;
                        dly_r         <= relDly;
                        state_r       <= MBIC_RAMPUP;
                    end
                end
                MBIC_RAMPUP: begin
                    if (!wantRun) begin
                        rampDown_r <= 1'b1;
                        dly_r      <= aplDly;
                        state_r    <= MBIC_RAMPDN;
                    end else if (starterVariant) begin
                        if (dly_r == '0) begin
                            brakeRelease_r <= 1'b1;
                            state_r        <= MBIC_RUN;
                        end
                    end else if (brakeSequenceSelect == SEQ_SIMPLE) begin
                        if (aboveOpen) begin
                            brakeRelease_r <= 1'b1;
                            state_r        <= MBIC_RUN;
                        end
                    end else if (outputFrequency >= brakeOpenFrequency) begin
                        freqHold_r <= 1'b1;
                        state_r    <= MBIC_TORQUE;
                    end
                end
                MBIC_TORQUE: begin
                    if (!wantRun) begin
                        freqHold_r <= 1'b0;
                        rampDown_r <= 1'b1;
                        state_r    <= MBIC_RAMPDN;
                    end else if (torqueOk) begin
                        brakeRelease_r <= 1'b1;
                        dly_r          <= relDly;
                        state_r        <= MBIC_HOLD;
                    end
                end
                MBIC_HOLD: begin
                    if (!wantRun) begin
                        freqHold_r <= 1'b0;
                        rampDown_r <= 1'b1;
                        state_r    <= MBIC_RAMPDN;
                    end else if (dly_r == '0) begin
                        freqHold_r <= 1'b0;
                        state_r    <= MBIC_RUN;
                    end
                end
                MBIC_RUN: begin
                    if (!wantRun) begin
                        rampDown_r <= 1'b1;
                        dly_r      <= aplDly;
                        state_r    <= MBIC_RAMPDN;
                    end
                end
                MBIC_RAMPDN: begin
                    if (starterVariant) begin
                        brakeRelease_r <= 1'b0;
                        dly_r          <= aplDly;
                        state_r        <= MBIC_APPLY;
                    end else if (belowClose) begin
                        brakeRelease_r <= 1'b0;
                        state_r        <= MBIC_APPLY;
                    end
                end
                MBIC_APPLY: begin
                    // starter waits apply delay; speed ctrl waits standstill
                    if (starterVariant ? (dly_r == '0)
                                       : (outputFrequency == '0)) begin
                        driveEnable_r <= 1'b0;
                        runForward_r  <= 1'b0;
                        runReverse_r  <= 1'b0;
                        rampDown_r    <= 1'b0;
                        state_r       <= MBIC_IDLE;
                    end
                end
                default: begin
                    brakeRelease_r <= 1'b0;
                    driveEnable_r  <= 1'b0;
                    state_r        <= MBIC_IDLE;
                end
            endcase
        end
    end
endmodule // mbic_control
`default_nettype wire

//--- logic/mbic_pkg.sv
`default_nettype none
package mbic_pkg;
    // frequency in units of 0.1 Hz, torque in percent of rated torque
    localparam int FREQ_W = 16;
    localparam int TORQ_W = 8;
    localparam int DLY_W  = 12;   // delay setting in units of 0.1 s
    localparam logic [FREQ_W-1:0] OPEN_FREQ_DEF  = 16'h000F; // 1.5 Hz
    localparam logic [FREQ_W-1:0] CLOSE_FREQ_DEF = 16'h000A; // 1.0 Hz
    localparam logic [TORQ_W-1:0] TORQ_DEF       = 8'h00;
    localparam logic [DLY_W-1:0]  DLY_MAX        = 12'h0C80; // 320.0 s
    localparam logic              SEQ_SIMPLE     = 1'b0;
    localparam logic              SEQ_ADVANCED   = 1'b1;
    localparam logic [2:0]        METHOD_VF      = 3'h6;
    // timing: one delay tick is 100 ms
    localparam int CLK_HZ       = 100_000_000;
    localparam int TICK_MS      = 100;
    localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
    // indicator flash half period
    localparam int FLASH_MS     = 250;
    localparam int FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;
    localparam int PRE_W        = 32;

    typedef enum logic [2:0] {
        MBIC_IDLE   = 3'b000,
        MBIC_RAMPUP = 3'b001,
        MBIC_TORQUE = 3'b010,
        MBIC_HOLD   = 3'b011,
        MBIC_RUN    = 3'b100,
        MBIC_RAMPDN = 3'b101,
        MBIC_APPLY  = 3'b110
    } mbic_state_t;
endpackage
`default_nettype wire

//--- tb/mbic_drive_model.sv
`timescale 1ns/1ns
`default_nettype none
module mbic_drive_model
    import mbic_pkg::*;
#(
    parameter logic [mbic_pkg::FREQ_W-1:0] SETPOINT = 16'h0032
) (
    // clock and reset
    input wire logic                        clk,
    input wire logic                        reset,
    // requests from the sequencer
    input wire logic                        driveEnable,
    input wire logic                        freqHold,
    input wire logic                        rampDown,
    // output frequency in 0.1 Hz
    output logic [mbic_pkg::FREQ_W-1:0]     outputFrequency
);
    // one step a cycle; a disabled inverter shows zero at once
    always_ff @(posedge clk) begin
        if (reset || !driveEnable) begin
            outputFrequency <= 16'h0000;
        end else if (rampDown) begin
            if (outputFrequency != 16'h0000) begin
                outputFrequency <= outputFrequency - 16'h0001;
            end
        end else if (!freqHold && outputFrequency < SETPOINT) begin
            outputFrequency <= outputFrequency + 16'h0001;
        end
    end
endmodule // mbic_drive_model
`default_nettype wire

//--- tb/mbic_control_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module mbic_control_asserts
    import mbic_pkg::*;
(
    // clock and reset
    input wire logic                        clk,
    input wire logic                        reset,
    // settings and commands
    input wire logic                        starterVariant,
    input wire logic                        autoMode,
    input wire logic                        brakeSequenceSelect,
    input wire logic                        firstSensorInput,
    input wire logic                        firstSensorFalling,
    input wire logic                        selForward,
    input wire logic [2:0]                  motorControlMethod,
    input wire logic [mbic_pkg::FREQ_W-1:0] brakeOpenFrequency,
    input wire logic [mbic_pkg::FREQ_W-1:0] brakeCloseFrequency,
    input wire logic [mbic_pkg::TORQ_W-1:0] torqueLevel,
    input wire logic [mbic_pkg::FREQ_W-1:0] outputFrequency,
    input wire logic [mbic_pkg::TORQ_W-1:0] motorTorque,
    // design outputs
    input wire logic                        runForward_r,
    input wire logic                        runReverse_r,
    input wire logic                        ledForward_r,
    input wire logic                        brakeRelease_r,
    input wire logic                        driveEnable_r,
    input wire logic                        freqHold_r,
    input wire logic [1:0]                  lockState_r
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    // thresholds are judged on the frequency seen one edge earlier
    AST_RESET_SAFE: assert property (
        $fell(reset) |-> !brakeRelease_r && !driveEnable_r)
        else $error("active right after reset");
    AST_BRAKE_DRIVE: assert property (
        !driveEnable_r |-> !brakeRelease_r)
        else $error("brake released with drive off");
    AST_OPEN_FREQ: assert property (
        $rose(brakeRelease_r) && !starterVariant && !brakeSequenceSelect
        |-> $past(outputFrequency) > brakeOpenFrequency)
        else $error("brake released below open level");
    AST_CLOSE_FREQ: assert property (
        $fell(brakeRelease_r) && driveEnable_r && !starterVariant
        |-> $past(outputFrequency) < brakeCloseFrequency)
        else $error("brake applied above close level");
    AST_TORQUE: assert property (
        $rose(brakeRelease_r) && !starterVariant && brakeSequenceSelect
        && motorControlMethod != METHOD_VF
        |-> $past(motorTorque) >= torqueLevel)
        else $error("brake released without torque");
    // a run already going keeps its direction while it ramps down, so the
    // lock is judged at the start of a manual run
    AST_LOCK_FWD: assert property (
        $rose(runForward_r) && !$past(autoMode) |-> !lockState_r[0])
        else $error("locked forward started");
    AST_STARTER_LOCK: assert property (
        ($rose(runForward_r) || $rose(runReverse_r)) && starterVariant
        && !$past(autoMode) |-> lockState_r == 2'b00)
        else $error("starter started manual while locked");
    AST_LED_STEADY: assert property (
        (!autoMode && !starterVariant && selForward && !lockState_r[0]
        && firstSensorInput == firstSensorFalling) [*3] |-> ledForward_r)
        else $error("forward indicator not lit");
    // main scenarios reached
    cover property (brakeRelease_r && !brakeSequenceSelect);
    cover property (lockState_r[0] && selForward);
    cover property (freqHold_r && brakeRelease_r);
endmodule // mbic_control_asserts
bind mbic_control mbic_control_asserts u_chk (
    .clk, .reset, .starterVariant, .autoMode, .brakeSequenceSelect,
    .firstSensorInput, .firstSensorFalling, .selForward,
    .motorControlMethod, .brakeOpenFrequency, .brakeCloseFrequency,
    .torqueLevel, .outputFrequency, .motorTorque, .runForward_r,
    .runReverse_r, .ledForward_r, .brakeRelease_r, .driveEnable_r,
    .freqHold_r, .lockState_r
);
`default_nettype wire

//--- tb/mbic_control_bench.sv
`timescale 1ns/1ns
`default_nettype none
module mbic_control_bench;
    import mbic_pkg::*;
    localparam int TK = 10;
    // stimulus, valued at time zero
    logic clk = 1'b0, reset = 1'b1, starterVariant = 1'b0;
    logic edgeInterlockSelect = 1'b0, autoMode = 1'b0;
    logic firstSensorInput = 1'b0, secondSensorInput = 1'b0;
    logic firstSensorFalling = 1'b0, secondSensorFalling = 1'b0;
    logic selForward = 1'b0, selReverse = 1'b0;
    logic autoForward = 1'b0, autoReverse = 1'b0;
    logic brakeSequenceSelect = SEQ_SIMPLE;
    logic [FREQ_W-1:0] brakeOpenFrequency = OPEN_FREQ_DEF;
    logic [FREQ_W-1:0] brakeCloseFrequency = CLOSE_FREQ_DEF;
    logic [TORQ_W-1:0] torqueLevel = 8'h32, motorTorque = 8'h00;
    logic [DLY_W-1:0] releaseDelay = 12'h003, applyDelay = 12'h002;
    logic [2:0] motorControlMethod = 3'h0;
    // observed
    logic [FREQ_W-1:0] outputFrequency;
    logic runForward_r, runReverse_r, ledForward_r, ledReverse_r;
    logic brakeRelease_r, driveEnable_r, freqHold_r, rampDown_r;
    logic [1:0] lockState_r;
    logic on, off;
    int fail_count = 0, n_tests = 0, n;
    always #5 clk = ~clk;
    // short tick and flash keep the delays within a short run
    mbic_control #(.TICK_CYC(TK), .FLASH_CYC(4)) u_dut (
        .clk, .reset, .starterVariant, .edgeInterlockSelect, .autoMode,
        .firstSensorInput, .secondSensorInput, .firstSensorFalling,
        .secondSensorFalling, .selForward, .selReverse, .autoForward,
        .autoReverse, .brakeSequenceSelect, .brakeOpenFrequency,
        .brakeCloseFrequency, .torqueLevel, .releaseDelay, .applyDelay,
        .motorControlMethod, .outputFrequency, .motorTorque, .runForward_r,
        .runReverse_r, .ledForward_r, .ledReverse_r, .brakeRelease_r,
        .driveEnable_r, .freqHold_r, .rampDown_r, .lockState_r
    );
    mbic_drive_model u_drv (
        .clk, .reset, .driveEnable(driveEnable_r), .freqHold(freqHold_r),
        .rampDown(rampDown_r), .outputFrequency
    );
    task automatic results();
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    function automatic logic sig(input int s);
        case (s)
            0: return brakeRelease_r;
            1: return driveEnable_r;
            2: return freqHold_r;
            3: return lockState_r[0];
            4: return runReverse_r;
            default: return runForward_r;
        endcase
    endfunction
    // bounded wait; n gives the cycles it took
    task automatic waitSig(input int s, input logic v);
        n = 0;
        while (sig(s) !== v) begin
            @(negedge clk);
            n++;
            if (n > 4000) begin
                fail_count++;
                results();
            end
        end
    endtask
    initial begin
        repeat (3) @(negedge clk);
        reset = 1'b0;
        chk("brake", brakeRelease_r, 1'b0);
        // simple sequence, speed controller
        selForward = 1'b1;
        waitSig(1, 1'b1);
        chk("runFwd", runForward_r, 1'b1);
        waitSig(0, 1'b1);
        chk("open", outputFrequency > brakeOpenFrequency
            && outputFrequency <= brakeOpenFrequency + 4, 1'b1);
        selForward = 1'b0;
        waitSig(0, 1'b0);
        chk("close", outputFrequency < brakeCloseFrequency, 1'b1);
        chk("rampOn", driveEnable_r, 1'b1);
        chk("rampDn", rampDown_r, 1'b1);
        waitSig(1, 1'b0);
        // forward lockout, flashing, opposite direction
        selForward = 1'b1;
        waitSig(1, 1'b1);
        firstSensorInput = 1'b1;
        waitSig(3, 1'b1);
        repeat (3) @(negedge clk);
        chk("lockRun", runForward_r, 1'b0);
        on = 1'b0;
        off = 1'b0;
        repeat (16) begin
            @(negedge clk);
            on |= ledForward_r;
            off |= !ledForward_r;
        end
        chk("flash", {on, off}, 2'b11);
        selForward = 1'b0;
        selReverse = 1'b1;
        waitSig(4, 1'b1);
        chk("revLed", ledReverse_r, 1'b1);
        selReverse = 1'b0;
        waitSig(1, 1'b0);
        firstSensorInput = 1'b0;
        waitSig(3, 1'b0);
        // inverted polarity: low level is active
        firstSensorFalling = 1'b1;
        firstSensorInput = 1'b1;
        repeat (4) @(negedge clk);
        chk("polIdle", lockState_r[0], 1'b0);
        firstSensorInput = 1'b0;
        waitSig(3, 1'b1);
        firstSensorInput = 1'b1;
        waitSig(3, 1'b0);
        firstSensorFalling = 1'b0;
        firstSensorInput = 1'b0;
        // second sensor locks reverse the same way
        secondSensorInput = 1'b1;
        repeat (3) @(negedge clk);
        chk("revLock", lockState_r, 2'b10);
        secondSensorInput = 1'b0;
        repeat (3) @(negedge clk);
        chk("revFree", lockState_r, 2'b00);
        // starter: timed release and apply
        starterVariant = 1'b1;
        edgeInterlockSelect = 1'b1;
        selForward = 1'b1;
        waitSig(0, 1'b1);
        chk("relDly", n >= 2*TK && n <= 4*TK + 4, 1'b1);
        selForward = 1'b0;
        repeat (2) @(negedge clk);
        chk("apply", brakeRelease_r, 1'b0);
        waitSig(1, 1'b0);
        chk("appDly", n >= TK - 2 && n <= 3*TK + 2, 1'b1);
        // starter lockout on edges only
        selForward = 1'b1;
        firstSensorInput = 1'b1;
        waitSig(3, 1'b1);
        selForward = 1'b0;
        selReverse = 1'b1;
        repeat (4) @(negedge clk);
        chk("stLock", runReverse_r, 1'b0);
        autoMode = 1'b1;
        repeat (2) @(negedge clk);
        autoMode = 1'b0;
        repeat (3) @(negedge clk);
        chk("edgeOnly", lockState_r, 2'b00);
        selReverse = 1'b0;
        selForward = 1'b1;
        waitSig(5, 1'b1);
        selForward = 1'b0;
        waitSig(1, 1'b0);
        autoMode = 1'b1;
        autoForward = 1'b1;
        waitSig(0, 1'b1);
        autoForward = 1'b0;
        waitSig(1, 1'b0);
        autoMode = 1'b0;
        firstSensorInput = 1'b0;
        starterVariant = 1'b0;
        edgeInterlockSelect = 1'b0;
        // advanced sequence
        brakeSequenceSelect = SEQ_ADVANCED;
        selForward = 1'b1;
        waitSig(2, 1'b1);
        repeat (5) @(negedge clk);
        chk("torqWait", brakeRelease_r, 1'b0);
        motorTorque = 8'h40;
        waitSig(0, 1'b1);
        chk("holdOn", freqHold_r, 1'b1);
        waitSig(2, 1'b0);
        chk("holdDly", n >= 2*TK - 2 && n <= 4*TK + 2, 1'b1);
        selForward = 1'b0;
        waitSig(1, 1'b0);
        motorTorque = 8'h00;
        motorControlMethod = METHOD_VF;
        selForward = 1'b1;
        waitSig(0, 1'b1);
        // reset in mid-run
        reset = 1'b1;
        selForward = 1'b0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        chk("rstBrake", brakeRelease_r, 1'b0);
        chk("rstDrive", driveEnable_r, 1'b0);
        results();
    end
endmodule // mbic_control_bench
`default_nettype wire
